// *** packer_pkg.sv ***
// Purpose: shared constants and types for the serial delimiter packer
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes:   offsets are byte addresses of 32-bit words
package packer_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  localparam int unsigned BUF_DEPTH = 1024;
  localparam int unsigned CNT_W     = 11;
  localparam int unsigned ADDR_W    = 10;

  localparam logic [7:0] OFS_DELIM  = 8'h00;
  localparam logic [7:0] OFS_FORCE  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FRAMES = 8'h0c;

  localparam int unsigned DELIM1_LSB  = 0;
  localparam int unsigned DELIM2_LSB  = 8;
  localparam int unsigned MATCH2_BIT  = 16;
  localparam int unsigned PROC_LSB    = 17;
  localparam int unsigned FORCE_LSB   = 0;
  localparam int unsigned STATE_LSB   = 16;

  localparam logic [7:0]  DELIM1_RST = 8'h00;
  localparam logic [7:0]  DELIM2_RST = 8'h00;
  localparam logic        MATCH2_RST = 1'b1;
  localparam logic [1:0]  PROC_RST   = 2'h0;
  localparam logic [15:0] FORCE_RST  = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PROC_NONE  = 2'h0,
    PROC_PLUS1 = 2'h1,
    PROC_PLUS2 = 2'h2
  } proc_type;

  typedef enum logic [2:0] {
    ST_COLLECT = 3'b001,
    ST_TRAIL   = 3'b010,
    ST_DRAIN   = 3'b100
  } state_type;

  typedef struct packed {
    logic [7:0]  delim1;
    logic [7:0]  delim2;
    logic        match_two;
    logic [1:0]  proc_sel;
    logic [15:0] force_ms;
  } cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic [CNT_W-1:0] len;
  } frame_beat_type;

endpackage

// *** idle_timer.sv ***
// Purpose: millisecond idle-gap timer with prescaler
// Assumes: restart pulses on every received byte
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ps
module idle_timer #(
  parameter int unsigned CYCLES_PER_MS = packer_pkg::CYCLES_PER_MS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        arm,
  input  wire logic        restart,
  input  wire logic [15:0] limit_ms,
  output logic             expired
);

  logic [31:0] pre_r;
  logic [15:0] ms_r;

  // prescaled ms ticks, cleared by each byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r   <= 32'h0000_0000;
      ms_r    <= 16'h0000;
      expired <= 1'b0;
    end else if (ce) begin
      if (restart || !arm || limit_ms == 16'h0000) begin
        pre_r   <= 32'h0000_0000;
        ms_r    <= 16'h0000;
        expired <= 1'b0;
      end else if (pre_r == CYCLES_PER_MS - 1) begin
        pre_r <= 32'h0000_0000;
        if (ms_r + 16'h0001 == limit_ms) begin
          ms_r    <= 16'h0000;
          expired <= 1'b1;
        end else begin
          ms_r    <= ms_r + 16'h0001;
          expired <= 1'b0;
        end
      end else begin
        pre_r   <= pre_r + 32'h0000_0001;
        expired <= 1'b0;
      end
    end
  end

endmodule // idle_timer

// *** serial_delimiter_packer.sv ***
// Purpose: packs received serial bytes into frames for the network side
// Assumes: AXI4-Lite configuration, one clock, synchronous active-low reset
// Notes:   frames leave as a byte stream with length and last marker
// Function
// - with no delimiter set, every received byte is sent on at once.
// - with a delimiter set, bytes are held until the delimiter arrives, then sent.
// - delimiters are 8-bit values; both zero disables delimiting.
// - second delimiter zero means single-character delimiter, else second character.
// - a full 1K buffer is closed as a frame and emptied.
// - one-byte match closes on either delimiter character; here only with no trailing action, else it needs first then second.
// - two-byte match closes only on first followed by second character.
// - match setting defaults to two bytes, only effective while delimiting.
// - trailing action needs first delimiter; with both, both must arrive.
// - trailing action sends on delimiter, after one, or after two more bytes.
// - zero force-transmit timeout disables the idle gap timer.
// - idle gap of 1 to 65535 ms closes the buffered bytes as a frame.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module serial_delimiter_packer #(
  parameter int unsigned CYCLES_PER_MS = packer_pkg::CYCLES_PER_MS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output packer_pkg::frame_beat_type tx_beat,
  input  wire logic        tx_ready
);

  packer_pkg::cfg_type   cfg_r;
  packer_pkg::state_type state_r;
  logic [7:0]  mem [packer_pkg::BUF_DEPTH];
  logic [packer_pkg::CNT_W-1:0] cnt_r;
  logic [packer_pkg::CNT_W-1:0] rd_r;
  logic [1:0]  trail_r;
  logic        prev_d1_r;
  logic [31:0] frames_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_got_r;
  logic        w_got_r;

  logic        accept;
  logic        delim_en;
  logic        hit;
  logic        expired;
  logic        close_now;
  logic        full_nxt;
  logic [31:0] delim_wr;
  logic [31:0] force_wr;
  logic [packer_pkg::CNT_W-1:0] cnt_nxt;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == packer_pkg::OFS_DELIM) || (a == packer_pkg::OFS_FORCE) ||
             (a == packer_pkg::OFS_STATUS) || (a == packer_pkg::OFS_FRAMES);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] cfg_word(input packer_pkg::cfg_type c);
    cfg_word = 32'h0000_0000;
    cfg_word[packer_pkg::DELIM1_LSB +: 8] = c.delim1;
    cfg_word[packer_pkg::DELIM2_LSB +: 8] = c.delim2;
    cfg_word[packer_pkg::MATCH2_BIT]      = c.match_two;
    cfg_word[packer_pkg::PROC_LSB +: 2]   = c.proc_sel;
  endfunction

  // delimiter decode
  assign accept   = rx_valid && rx_ready;
  assign delim_en = (cfg_r.delim1 != 8'h00) || (cfg_r.delim2 != 8'h00);
  assign cnt_nxt  = cnt_r + 11'h001;
  assign full_nxt = (cnt_nxt == packer_pkg::CNT_W'(packer_pkg::BUF_DEPTH));

  // pending write merged onto current settings
  assign delim_wr = merge(cfg_word(cfg_r), w_data_r, w_strb_r);
  assign force_wr = merge({16'h0000, cfg_r.force_ms}, w_data_r, w_strb_r);

  always_comb begin
    hit = 1'b0;
    if (cfg_r.delim2 == 8'h00) begin
      hit = (rx_data == cfg_r.delim1);
    end else if (cfg_r.delim1 == 8'h00 || (!cfg_r.match_two && cfg_r.proc_sel == packer_pkg::PROC_NONE)) begin
      hit = (rx_data == cfg_r.delim2) || (cfg_r.delim1 != 8'h00 && rx_data == cfg_r.delim1);
    end else begin
      hit = prev_d1_r && (rx_data == cfg_r.delim2);
    end
  end

  always_comb begin
    close_now = 1'b0;
    if (accept) begin
      if (!delim_en) begin
        close_now = 1'b1;
      end else if (state_r == packer_pkg::ST_TRAIL) begin
        close_now = (trail_r == 2'h1) || full_nxt;
      end else begin
        close_now = (hit && (cfg_r.delim1 == 8'h00 || cfg_r.proc_sel == packer_pkg::PROC_NONE)) ||
                    full_nxt;
      end
    end else if (expired && cnt_r != 11'h000 && state_r != packer_pkg::ST_DRAIN) begin
      close_now = 1'b1;
    end
  end

  idle_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_idle (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .arm      (cnt_r != 11'h000 && state_r != packer_pkg::ST_DRAIN),
    .restart  (accept),
    .limit_ms (cfg_r.force_ms),
    .expired  (expired)
  );

  // buffer writes
  always_ff @(posedge aclk) begin
    if (ce && accept) begin
      mem[cnt_r[packer_pkg::ADDR_W-1:0]] <= rx_data;
    end
  end

  // collection and drain sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= packer_pkg::ST_COLLECT;
      cnt_r     <= 11'h000;
      rd_r      <= 11'h000;
      rx_ready  <= 1'b1;
      tx_beat   <= '0;
    end else if (ce) begin
      unique case (state_r)
        packer_pkg::ST_COLLECT,
        packer_pkg::ST_TRAIL: begin
          if (accept) begin
            cnt_r <= cnt_nxt;
          end
          if (close_now) begin
            state_r  <= packer_pkg::ST_DRAIN;
            rx_ready <= 1'b0;
            rd_r     <= 11'h000;
          end else if (accept && hit && delim_en && state_r == packer_pkg::ST_COLLECT) begin
            state_r <= packer_pkg::ST_TRAIL;
          end
        end
        packer_pkg::ST_DRAIN: begin
          if (!tx_beat.valid || tx_ready) begin
            if (rd_r != cnt_r) begin
              tx_beat.valid <= 1'b1;
              tx_beat.data  <= mem[rd_r[packer_pkg::ADDR_W-1:0]];
              tx_beat.last  <= (rd_r + 11'h001 == cnt_r);
              tx_beat.len   <= cnt_r;
              rd_r          <= rd_r + 11'h001;
            end else begin
              tx_beat.valid <= 1'b0;
              tx_beat.last  <= 1'b0;
              cnt_r         <= 11'h000;
              state_r       <= packer_pkg::ST_COLLECT;
              rx_ready      <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // first delimiter seen on the previous byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_d1_r <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        prev_d1_r <= (rx_data == cfg_r.delim1) && (cfg_r.delim1 != 8'h00);
      end else if (state_r == packer_pkg::ST_DRAIN && rd_r == cnt_r && (!tx_beat.valid || tx_ready)) begin
        prev_d1_r <= 1'b0;
      end
    end
  end

  // trailing bytes still owed after a delimiter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trail_r <= 2'h0;
    end else if (ce && accept && !close_now) begin
      if (state_r == packer_pkg::ST_TRAIL) begin
        trail_r <= trail_r - 2'h1;
      end else if (hit && delim_en) begin
        trail_r <= cfg_r.proc_sel;
      end
    end
  end

  // closed-frame counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames_r <= 32'h0000_0000;
    end else if (ce && close_now) begin
      frames_r <= frames_r + 32'h0000_0001;
    end
  end

  // register write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r.delim1    <= packer_pkg::DELIM1_RST;
      cfg_r.delim2    <= packer_pkg::DELIM2_RST;
      cfg_r.match_two <= packer_pkg::MATCH2_RST;
      cfg_r.proc_sel  <= packer_pkg::PROC_RST;
      cfg_r.force_ms  <= packer_pkg::FORCE_RST;
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      aw_addr_r       <= 8'h00;
      w_data_r        <= 32'h0000_0000;
      w_strb_r        <= 4'h0;
      s_axi_awready   <= 1'b1;
      s_axi_wready    <= 1'b1;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= packer_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? packer_pkg::RESP_OKAY : packer_pkg::RESP_SLVERR;
        if (aw_addr_r == packer_pkg::OFS_DELIM) begin
          cfg_r.delim1    <= delim_wr[packer_pkg::DELIM1_LSB +: 8];
          cfg_r.delim2    <= delim_wr[packer_pkg::DELIM2_LSB +: 8];
          cfg_r.match_two <= delim_wr[packer_pkg::MATCH2_BIT];
          cfg_r.proc_sel  <= delim_wr[packer_pkg::PROC_LSB +: 2];
        end else if (aw_addr_r == packer_pkg::OFS_FORCE) begin
          cfg_r.force_ms <= force_wr[packer_pkg::FORCE_LSB +: 16];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= packer_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? packer_pkg::RESP_OKAY : packer_pkg::RESP_SLVERR;
        unique case (s_axi_araddr)
          packer_pkg::OFS_DELIM:  s_axi_rdata <= cfg_word(cfg_r);
          packer_pkg::OFS_FORCE:  s_axi_rdata <= {16'h0000, cfg_r.force_ms};
          packer_pkg::OFS_STATUS: s_axi_rdata <= {13'h0000, state_r, 5'h00, cnt_r};
          packer_pkg::OFS_FRAMES: s_axi_rdata <= frames_r;
          default:                s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // serial_delimiter_packer

// *** packer_assertions.sv ***
// Purpose: port checks for the delimiter packer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module packer_assertions (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       rx_ready,
  input wire packer_pkg::frame_beat_type tx_beat,
  input wire logic                       tx_ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_beat_hold: assert property (tx_beat.valid && !tx_ready |=> tx_beat.valid && $stable(tx_beat))
    else $error("beat changed before taken");
  a_len_range: assert property (tx_beat.valid |-> tx_beat.len != 11'h000 && tx_beat.len <= 11'h400)
    else $error("frame length out of range");
  a_single_last: assert property (tx_beat.valid && tx_beat.len == 11'h001 |-> tx_beat.last)
    else $error("one-byte frame without last");
  a_rx_closed: assert property (tx_beat.valid |-> !rx_ready)
    else $error("input open while draining");
  a_len_const: assert property (tx_beat.valid && tx_ready && !tx_beat.last |=> tx_beat.valid && $stable(tx_beat.len))
    else $error("frame broken mid-drain");
  a_reopen_after: assert property (tx_beat.valid && tx_beat.last && tx_ready |=> !tx_beat.valid ##[0:1] rx_ready)
    else $error("buffer not restarted after frame");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
endmodule // packer_assertions

// *** net_sink.sv ***
// Purpose: network-side sink taking frame beats
// Assumes: slow high stalls every other cycle
// Notes:   latches length, count and final byte of each frame
`timescale 1ns/1ps
module net_sink (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       slow,
  input  wire packer_pkg::frame_beat_type tx_beat,
  output logic                            tx_ready,
  output logic [10:0]                     seen_len,
  output logic [10:0]                     seen_cnt,
  output logic [7:0]                      seen_last,
  output logic [15:0]                     frames
);
  logic [10:0] run_r;
  logic        ph_r;
  assign tx_ready = !slow || ph_r;
  // stall pattern
  always_ff @(posedge aclk) begin
    ph_r <= aresetn ? ~ph_r : 1'b0;
  end
  // frame capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 11'h000;
      frames <= 16'h0000;
    end else if (tx_beat.valid && tx_ready) begin
      run_r <= tx_beat.last ? 11'h000 : run_r + 11'h001;
      if (tx_beat.last) begin
        seen_cnt <= run_r + 11'h001;
        seen_len <= tx_beat.len;
        seen_last <= tx_beat.data;
        frames <= frames + 16'h0001;
      end
    end
  end
endmodule // net_sink

// *** serial_delimiter_packer_tb.sv ***
// Purpose: self-checking bench for the delimiter packer
// Assumes: ms prescale cut to 4 cycles, ce held high
// Notes:   ordinary cases are table rows
`timescale 1ns/1ps
module serial_delimiter_packer_tb;
  typedef struct packed {
    logic [31:0] cfg;
    logic [47:0] bytes;
    logic [10:0] len;
  } row_type;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_data = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_valid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_ready, tx_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
  logic [10:0] seen_len, seen_cnt;
  logic [7:0]  seen_last;
  logic [15:0] frames, f0;
  int          miscompares = 0;
  int          cmp_count = 0;
  packer_pkg::frame_beat_type tx_beat;
  row_type rows [9] = '{'{32'h0005_0000, 48'h41_00_00_00_00_00, 11'h001}, '{32'h0000_0a0d, 48'h41_0a_00_00_00_00, 11'h002},
                       '{32'h0001_0a0d, 48'h41_0a_0d_0a_00_00, 11'h004}, '{32'h0001_000d, 48'h41_42_0d_00_00_00, 11'h003},
                       '{32'h0002_000d, 48'h41_0d_42_00_00_00, 11'h003}, '{32'h0004_000d, 48'h41_0d_42_43_00_00, 11'h004},
                       '{32'h0003_0a0d, 48'h41_0d_0a_42_00_00, 11'h004}, '{32'h0004_0a00, 48'h41_0a_00_00_00_00, 11'h002},
                       '{32'h0002_0a0d, 48'h41_0a_0d_0a_42_00, 11'h005}};
  always #2 aclk = ~aclk;
  serial_delimiter_packer #(.CYCLES_PER_MS(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_beat(tx_beat), .tx_ready(tx_ready));
  net_sink sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_beat(tx_beat), .tx_ready(tx_ready),
    .seen_len(seen_len), .seen_cnt(seen_cnt), .seen_last(seen_last), .frames(frames));
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic stuck(input int n);
    if (n >= 5000) begin
      miscompares++;
      $display("[ERR] %0t wait timed out", $time);
      print_verdict();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 5000);
    bs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    stuck(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 5000);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    stuck(n);
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_data <= b;
    rx_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!rx_ready && n < 5000);
    stuck(n);
  endtask
  task automatic wait_frame(input logic [15:0] k);
    int n;
    n = 0;
    while (frames !== k && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    stuck(n);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(packer_pkg::OFS_DELIM, rd, rs);
    chk(rd, 32'h0001_0000, "delim reset");
    axi_rd(packer_pkg::OFS_FORCE, rd, rs);
    chk(rd, 32'h0000_0000, "force reset");
    axi_rd(8'h10, rd, rs);
    chk({30'h0, rs}, {30'h0, packer_pkg::RESP_SLVERR}, "unmapped resp");
    foreach (rows[i]) begin
      slow <= (i % 2 == 1);
      axi_wr(packer_pkg::OFS_DELIM, rows[i].cfg);
      f0 = frames;
      for (int j = 0; j < int'(rows[i].len); j++) send(rows[i].bytes[47-8*j -: 8]);
      rx_valid <= 1'b0;
      wait_frame(f0 + 16'h0001);
      chk({21'h0, seen_len}, {21'h0, rows[i].len}, "frame len");
      chk({21'h0, seen_cnt}, {21'h0, rows[i].len}, "beat count");
      chk({24'h0, seen_last}, {24'h0, rows[i].bytes[55-8*rows[i].len -: 8]}, "last byte");
    end
    axi_rd(packer_pkg::OFS_DELIM, rd, rs);
    chk(rd, rows[8].cfg, "delim readback");
    axi_rd(packer_pkg::OFS_FRAMES, rd, rs);
    chk(rd, 32'h0000_0009, "frame total");
    axi_rd(packer_pkg::OFS_STATUS, rd, rs);
    chk(rd, 32'h0001_0000, "idle status");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(packer_pkg::OFS_DELIM, rd, rs);
    chk(rd, 32'h0001_0000, "delim after reset");
    axi_wr(packer_pkg::OFS_DELIM, 32'h0000_000d);
    axi_wr(packer_pkg::OFS_FORCE, 32'h0000_0002);
    chk({30'h0, bs}, {30'h0, packer_pkg::RESP_OKAY}, "write resp");
    f0 = frames;
    send(8'h41);
    rx_valid <= 1'b0;
    repeat (6) @(posedge aclk);
    send(8'h42);
    rx_valid <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({16'h0, frames}, {16'h0, f0}, "early close");
    repeat (10) @(posedge aclk);
    chk({16'h0, frames}, {16'h0, f0 + 16'h0001}, "idle close");
    chk({21'h0, seen_len}, 32'h2, "idle len");
    axi_wr(packer_pkg::OFS_FORCE, 32'h0000_0000);
    slow <= 1'b0;
    f0 = frames;
    send(8'h41);
    rx_valid <= 1'b0;
    repeat (40) @(posedge aclk);
    chk({16'h0, frames}, {16'h0, f0}, "no timeout");
    repeat (1023) send(8'h42);
    rx_valid <= 1'b0;
    wait_frame(f0 + 16'h0001);
    chk({21'h0, seen_len}, 32'h400, "full len");
    chk({24'h0, seen_last}, 32'h42, "full last");
    send(8'h0d);
    rx_valid <= 1'b0;
    wait_frame(f0 + 16'h0002);
    chk({21'h0, seen_len}, 32'h1, "after full");
    print_verdict();
  end
endmodule // serial_delimiter_packer_tb
bind serial_delimiter_packer packer_assertions chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .rx_ready(rx_ready),
  .tx_beat(tx_beat), .tx_ready(tx_ready));
